// file: rtl/fcsr_top.sv
`timescale 1ns/1ps
// What this block does
// - Context control bit 1 records user privilege at frame allocation.
// - Context control bit 0 reads 1 while lazy save is pending.
// - Frame address bits 31:3 hold the reserved empty register area.
// - Frame address bits 2:0 read zero; writes to them are dropped.
// - Status bits 31:28 hold N Z C V, updated by compares.
// - Bit 26 selects IEEE half format at 0, alternative at 1.
// - Bit 25 set makes NaN inputs return the default NaN.
// - Bit 24 set enables flush-to-zero, clear means full IEEE 754.
// - Bits 23:22 select nearest, plus, minus or toward-zero rounding.
// - Sticky exception bits 7 and 4:0 stay set until software writes 0.
// - Default status register holds mode defaults in bits 26:22.
// - The unit leaves reset disabled; instructions fault until enabled.
// - Access register reads and writes are allowed only when privileged.
// - Access fields: denied, privileged only, reserved, full access.
// - Default status register is read-write and resets to zero.
module fcsr_top
  import fcsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic bus_priv,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_err,
  input wire logic scr_write,
  input wire logic [31:0] scr_wdata,
  output logic [31:0] scr_rdata,
  input wire logic cmp_valid,
  input wire logic [3:0] cmp_flags,
  input wire logic [5:0] exc_flags,
  input wire logic frame_alloc,
  input wire logic [31:0] frame_addr,
  input wire logic alloc_user,
  input wire logic lazy_save_done,
  input wire logic new_context,
  input wire logic fp_instr_valid,
  input wire logic fp_instr_priv,
  output logic no_coproc_fault,
  output logic alt_half_select,
  output logic default_nan_ctrl,
  output logic flush_to_zero_ctrl,
  output fcsr_round_t rounding_select
);

  fcsr_state_t state_r;
  fcsr_state_t state_nxt;
  logic [31:0] rd_word;

  fcsr_acc_if acc ();

  assign acc.cp_first = state_r.acc_reg[CP_FIRST_LO +: 2];
  assign acc.cp_second = state_r.acc_reg[CP_SECOND_LO +: 2];
  assign acc.instr_valid = fp_instr_valid;
  assign acc.instr_priv = fp_instr_priv;

  fcsr_access i_fcsr_access (
    .mclk(mclk),
    .rst_b(rst_b),
    .acc(acc)
  );

  always_comb begin
    state_nxt = state_r;
    rd_word = ZERO_WORD;
    state_nxt.err = 1'h0;
    state_nxt.fault = acc.fault;
    if (bus_sel) begin
      case (bus_addr)
        ADDR_CCR: begin
          rd_word = state_r.ccr;
          if (bus_write) begin
            state_nxt.ccr = bus_wdata & CCR_MASK;
          end
        end
        ADDR_CAR: begin
          rd_word = state_r.car;
          if (bus_write) begin
            state_nxt.car = bus_wdata & CAR_MASK;
          end
        end
        ADDR_DSCR: begin
          rd_word = state_r.dscr;
          if (bus_write) begin
            state_nxt.dscr = bus_wdata & DSCR_MASK;
          end
        end
        ADDR_ACC: begin
          // An unprivileged access is refused and leaves the field as it was.
          if (bus_priv) begin
            rd_word = state_r.acc_reg;
            if (bus_write) begin
              state_nxt.acc_reg = bus_wdata & ACC_MASK;
            end
          end else begin
            state_nxt.err = 1'h1;
          end
        end
        default: begin
          state_nxt.err = 1'h1;
        end
      endcase
      state_nxt.rdata = bus_write ? ZERO_WORD : rd_word;
    end
    // Hardware events come after software writes so that a hardware update always wins.
    if (lazy_save_done) begin
      state_nxt.ccr[CCR_LAZY] = 1'h0;
    end
    if (frame_alloc) begin
      state_nxt.car = frame_addr & CAR_MASK;
      state_nxt.ccr[CCR_USER] = alloc_user;
      if (state_r.ccr[CCR_LSPEN]) begin
        state_nxt.ccr[CCR_LAZY] = 1'h1;
      end
    end
    if (scr_write) begin
      state_nxt.scr = scr_wdata & SCR_MASK;
    end
    if (new_context) begin
      state_nxt.scr = (state_nxt.scr & ~DSCR_MASK) |
        (state_r.dscr & DSCR_MASK);
    end
    if (cmp_valid) begin
      state_nxt.scr[SCR_FLAG_HI:SCR_FLAG_LO] = cmp_flags;
    end
    state_nxt.scr[SCR_DENORM] =
      state_nxt.scr[SCR_DENORM] | exc_flags[EXC_DENORM];
    state_nxt.scr[SCR_EXC_HI:0] =
      state_nxt.scr[SCR_EXC_HI:0] | exc_flags[SCR_EXC_HI:0];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= '{ccr: CCR_RESET, car: CAR_RESET, scr: SCR_RESET,
                   dscr: DSCR_RESET, acc_reg: ACC_RESET,
                   rdata: ZERO_WORD, err: 1'h0, fault: 1'h0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus_rdata = state_r.rdata;
  assign bus_err = state_r.err;
  assign scr_rdata = state_r.scr;
  assign no_coproc_fault = state_r.fault;
  assign alt_half_select = state_r.scr[SCR_ALT_HALF];
  assign default_nan_ctrl = state_r.scr[SCR_DNAN];
  assign flush_to_zero_ctrl = state_r.scr[SCR_FLUSH];
  assign rounding_select =
    fcsr_round_t'(state_r.scr[SCR_RM_HI:SCR_RM_LO]);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_user_rec;
    frame_alloc |=> state_r.ccr[CCR_USER] == $past(alloc_user);
  endproperty
  a_user_rec: assert property (p_user_rec)
    else $error("User flag not recorded at frame allocation.");

  property p_lazy_set;
    frame_alloc && state_r.ccr[CCR_LSPEN] |=> state_r.ccr[CCR_LAZY];
  endproperty
  a_lazy_set: assert property (p_lazy_set)
    else $error("Lazy save flag not set at frame allocation.");

  property p_car_load;
    frame_alloc |=> state_r.car[31:CAR_LSB] == $past(frame_addr[31:CAR_LSB]);
  endproperty
  a_car_load: assert property (p_car_load)
    else $error("Frame address not captured.");

  property p_car_low;
    bus_sel && (bus_addr == ADDR_CAR) && !bus_write
      |=> bus_rdata[CAR_LSB-1:0] == 3'h0;
  endproperty
  a_car_low: assert property (p_car_low)
    else $error("Frame address low bits read nonzero.");

  property p_cmp_flags;
    cmp_valid |=> scr_rdata[SCR_FLAG_HI:SCR_FLAG_LO] == $past(cmp_flags);
  endproperty
  a_cmp_flags: assert property (p_cmp_flags)
    else $error("Compare flags not updated.");

  property p_ftz_write;
    scr_write && !new_context
      |=> flush_to_zero_ctrl == $past(scr_wdata[SCR_FLUSH]);
  endproperty
  a_ftz_write: assert property (p_ftz_write)
    else $error("Flush-to-zero control not written.");

  property p_round_write;
    scr_write && !new_context
      |=> rounding_select == $past(scr_wdata[SCR_RM_HI:SCR_RM_LO]);
  endproperty
  a_round_write: assert property (p_round_write)
    else $error("Rounding select not written.");

  property p_sticky_hold;
    scr_rdata[0] && !(scr_write && !scr_wdata[0]) |=> scr_rdata[0];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("Sticky invalid-operation bit lost without a zero write.");

  property p_sticky_set;
    exc_flags[EXC_DENORM] |=> scr_rdata[SCR_DENORM];
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("Input denormal event not recorded.");

  property p_acc_unpriv;
    bus_sel && bus_write && !bus_priv && (bus_addr == ADDR_ACC)
      |=> bus_err && $stable(state_r.acc_reg);
  endproperty
  a_acc_unpriv: assert property (p_acc_unpriv)
    else $error("Unprivileged access register write not refused.");

  property p_dscr_write;
    bus_sel && bus_write && (bus_addr == ADDR_DSCR)
      |=> state_r.dscr == ($past(bus_wdata) & DSCR_MASK);
  endproperty
  a_dscr_write: assert property (p_dscr_write)
    else $error("Default status register not written.");

  property p_new_ctx;
    new_context && !cmp_valid ##1 1'h1
      |-> alt_half_select == $past(state_r.dscr[SCR_ALT_HALF]);
  endproperty
  a_new_ctx: assert property (p_new_ctx)
    else $error("Mode fields not loaded from defaults.");

  property p_fault_out;
    fp_instr_valid && (state_r.acc_reg == ACC_RESET) |=> no_coproc_fault;
  endproperty
  a_fault_out: assert property (p_fault_out)
    else $error("Instruction with unit disabled did not fault.");

endmodule : fcsr_top

// file: inc/fcsr_pkg.sv
package fcsr_pkg;

  // System addresses of the memory-mapped registers.
  localparam logic [31:0] ADDR_CCR = 32'hE000_EF34;
  localparam logic [31:0] ADDR_CAR = 32'hE000_EF38;
  localparam logic [31:0] ADDR_DSCR = 32'hE000_EF3C;
  localparam logic [31:0] ADDR_ACC = 32'hE000_ED88;

  // Reset values.
  localparam logic [31:0] CCR_RESET = 32'hC000_0000;
  localparam logic [31:0] CAR_RESET = 32'h0000_0000;
  localparam logic [31:0] SCR_RESET = 32'h0000_0000;
  localparam logic [31:0] DSCR_RESET = 32'h0000_0000;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Implemented-bit masks; all other bits read as zero.
  localparam logic [31:0] CCR_MASK = 32'hC000_0003;
  localparam logic [31:0] CAR_MASK = 32'hFFFF_FFF8;
  localparam logic [31:0] SCR_MASK = 32'hF7C0_009F;
  localparam logic [31:0] DSCR_MASK = 32'h07C0_0000;
  localparam logic [31:0] ACC_MASK = 32'h00F0_0000;

  // Field positions.
  localparam int CCR_LSPEN = 30;
  localparam int CCR_USER = 1;
  localparam int CCR_LAZY = 0;
  localparam int CAR_LSB = 3;
  localparam int SCR_FLAG_HI = 31;
  localparam int SCR_FLAG_LO = 28;
  localparam int SCR_ALT_HALF = 26;
  localparam int SCR_DNAN = 25;
  localparam int SCR_FLUSH = 24;
  localparam int SCR_RM_HI = 23;
  localparam int SCR_RM_LO = 22;
  localparam int SCR_DENORM = 7;
  localparam int SCR_EXC_HI = 4;
  localparam int EXC_DENORM = 5;
  localparam int CP_FIRST_LO = 20;
  localparam int CP_SECOND_LO = 22;

  typedef enum logic [1:0] {
    CP_DENY = 2'h0,
    CP_PRIV = 2'h1,
    CP_RESV = 2'h2,
    CP_FULL = 2'h3
  } fcsr_cp_t;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_PLUS_INF = 2'h1,
    RND_MINUS_INF = 2'h2,
    RND_ZERO = 2'h3
  } fcsr_round_t;

  typedef struct packed {
    logic [31:0] ccr;
    logic [31:0] car;
    logic [31:0] scr;
    logic [31:0] dscr;
    logic [31:0] acc_reg;
    logic [31:0] rdata;
    logic err;
    logic fault;
  } fcsr_state_t;

endpackage : fcsr_pkg

// file: inc/fcsr_acc_if.sv
`timescale 1ns/1ps
interface fcsr_acc_if;
  logic [1:0] cp_first;
  logic [1:0] cp_second;
  logic instr_valid;
  logic instr_priv;
  logic fault;

  modport core (
    output cp_first,
    output cp_second,
    output instr_valid,
    output instr_priv,
    input fault
  );

  modport gate (
    input cp_first,
    input cp_second,
    input instr_valid,
    input instr_priv,
    output fault
  );
endinterface : fcsr_acc_if

// file: rtl/fcsr_access.sv
`timescale 1ns/1ps
module fcsr_access
  import fcsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  fcsr_acc_if.gate acc
);

  // The reserved code is treated as denied so that it can never grant use.
  function automatic logic cp_denied(input logic [1:0] f, input logic priv);
    return (f == CP_DENY) || (f == CP_RESV) || ((f == CP_PRIV) && !priv);
  endfunction : cp_denied

  assign acc.fault = acc.instr_valid &&
    (cp_denied(acc.cp_first, acc.instr_priv) ||
     cp_denied(acc.cp_second, acc.instr_priv));

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_denied_faults;
    acc.instr_valid && (acc.cp_first == CP_DENY) |-> acc.fault;
  endproperty
  a_denied_faults: assert property (p_denied_faults)
    else $error("Denied coprocessor access did not fault.");

  property p_user_on_priv;
    acc.instr_valid && !acc.instr_priv && (acc.cp_second == CP_PRIV)
      |-> acc.fault;
  endproperty
  a_user_on_priv: assert property (p_user_on_priv)
    else $error("Unprivileged use of privileged-only field did not fault.");

  property p_full_grants;
    acc.instr_valid && (acc.cp_first == CP_FULL) &&
      (acc.cp_second == CP_FULL) |-> !acc.fault;
  endproperty
  a_full_grants: assert property (p_full_grants)
    else $error("Full access still produced a fault.");

endmodule : fcsr_access

// file: tb/fcsr_core_model.sv
`timescale 1ns/1ps
module fcsr_core_model
  import fcsr_pkg::*;
(
  input wire logic mclk,
  output logic bus_sel,
  output logic bus_write,
  output logic bus_priv,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata
);
  logic [31:0] last_rd = 32'h0000_0000;
  initial begin
    bus_sel = 1'h0;
    bus_write = 1'h0;
    bus_priv = 1'h0;
    bus_addr = 32'h0000_0000;
    bus_wdata = 32'h0000_0000;
  end
  // One load or store, held over exactly one taking edge.
  task automatic access(input logic wr, input logic pv,
                        input logic [31:0] a, input logic [31:0] d);
    @(negedge mclk);
    bus_sel = 1'h1;
    bus_write = wr;
    bus_priv = pv;
    bus_addr = a;
    bus_wdata = d;
    @(negedge mclk);
    last_rd = bus_rdata;
    bus_sel = 1'h0;
    // Released lines flip, so a stale value never passes for a live one.
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask : access
  task automatic enable_unit();
    access(1'h0, 1'h1, ADDR_ACC, 32'h0000_0000);
    access(1'h1, 1'h1, ADDR_ACC, last_rd | 32'h00F0_0000);
    // The store must land and the pipeline refill before fp code runs.
    repeat (2) @(negedge mclk);
  endtask : enable_unit
endmodule : fcsr_core_model

// file: tb/tb_fcsr_top.sv
`timescale 1ns/1ps
module tb_fcsr_top;
  import fcsr_pkg::*;
  logic mclk = 1'h0, rst_b = 1'h0, sel_d = 1'h0;
  logic bus_sel, bus_write, bus_priv, bus_err, no_coproc_fault;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, scr_rdata, v, es;
  logic scr_write = 1'h0, cmp_valid = 1'h0, frame_alloc = 1'h0;
  logic alloc_user = 1'h0, lazy_save_done = 1'h0, new_context = 1'h0;
  logic fp_instr_valid = 1'h0, fp_instr_priv = 1'h0;
  logic [31:0] scr_wdata = 32'h0000_0000, frame_addr = 32'h0000_0000;
  logic [3:0] cmp_flags = 4'h0;
  logic [5:0] exc_flags = 6'h00;
  logic alt_half_select, default_nan_ctrl, flush_to_zero_ctrl;
  fcsr_round_t rounding_select;
  logic [32:0] expq[$];
  logic [32:0] e;
  int mismatches = 0, checks_done = 0, cycles = 0;
  always #5 mclk = ~mclk;
  fcsr_top i_fcsr_top (.mclk(mclk), .rst_b(rst_b), .bus_sel(bus_sel),
    .bus_write(bus_write), .bus_priv(bus_priv), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_err(bus_err),
    .scr_write(scr_write), .scr_wdata(scr_wdata), .scr_rdata(scr_rdata),
    .cmp_valid(cmp_valid), .cmp_flags(cmp_flags), .exc_flags(exc_flags),
    .frame_alloc(frame_alloc), .frame_addr(frame_addr),
    .alloc_user(alloc_user), .lazy_save_done(lazy_save_done),
    .new_context(new_context), .fp_instr_valid(fp_instr_valid),
    .fp_instr_priv(fp_instr_priv), .no_coproc_fault(no_coproc_fault),
    .alt_half_select(alt_half_select), .default_nan_ctrl(default_nan_ctrl),
    .flush_to_zero_ctrl(flush_to_zero_ctrl),
    .rounding_select(rounding_select));
  fcsr_core_model i_fcsr_core_model (.mclk(mclk), .bus_sel(bus_sel),
    .bus_write(bus_write), .bus_priv(bus_priv), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("Mismatches %0d, checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic bus(input logic w, input logic p, input logic [31:0] a,
                     input logic [31:0] d, input logic [31:0] er,
                     input logic ee);
    expq.push_back({ee, er});
    i_fcsr_core_model.access(w, p, a, d);
  endtask : bus
  task automatic modes();
    check({27'h000_0000, alt_half_select, default_nan_ctrl,
      flush_to_zero_ctrl, rounding_select}, {27'h000_0000, es[26:22]});
  endtask : modes
  always @(posedge mclk) begin
    sel_d <= bus_sel & rst_b;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  always @(negedge mclk) begin
    if (sel_d) begin
      e = expq.pop_front();
      check(bus_rdata, e[31:0]);
      check({31'h0000_0000, bus_err}, {31'h0000_0000, e[32]});
    end
  end
  initial begin
    void'($urandom(32'h7bccf543));
    repeat (10) @(negedge mclk);
    rst_b = 1'h1;
    bus(1'h0, 1'h1, ADDR_CCR, ZERO_WORD, CCR_RESET, 1'h0);
    bus(1'h0, 1'h1, ADDR_CAR, ZERO_WORD, CAR_RESET, 1'h0);
    bus(1'h0, 1'h1, ADDR_DSCR, ZERO_WORD, DSCR_RESET, 1'h0);
    bus(1'h0, 1'h1, ADDR_ACC, ZERO_WORD, ACC_RESET, 1'h0);
    check(scr_rdata, SCR_RESET);
    for (int c = 0; c < 4; c++) begin
      v = {8'h00, c[1:0], c[1:0], 20'h0_0000};
      bus(1'h1, 1'h1, ADDR_ACC, v, ZERO_WORD, 1'h0);
      bus(1'h0, 1'h1, ADDR_ACC, ZERO_WORD, v, 1'h0);
      for (int p = 0; p < 2; p++) begin
        fp_instr_valid = 1'h1;
        fp_instr_priv = p[0];
        @(negedge mclk);
        fp_instr_valid = 1'h0;
        check({31'h0000_0000, no_coproc_fault}, {31'h0000_0000,
          c == 0 || c == 2 || (c == 1 && p == 0)});
        @(negedge mclk);
      end
    end
    bus(1'h1, 1'h0, ADDR_ACC, ZERO_WORD, ZERO_WORD, 1'h1);
    bus(1'h0, 1'h0, ADDR_ACC, ZERO_WORD, ZERO_WORD, 1'h1);
    bus(1'h0, 1'h1, ADDR_ACC, ZERO_WORD, ACC_MASK, 1'h0);
    bus(1'h0, 1'h1, 32'hE000_EF40, ZERO_WORD, ZERO_WORD, 1'h1);
    bus(1'h1, 1'h1, ADDR_ACC, ZERO_WORD, ZERO_WORD, 1'h0);
    expq.push_back({1'h0, ZERO_WORD});
    expq.push_back({1'h0, ZERO_WORD});
    i_fcsr_core_model.enable_unit();
    bus(1'h0, 1'h1, ADDR_ACC, ZERO_WORD, ACC_MASK, 1'h0);
    v = $urandom;
    bus(1'h1, 1'h1, ADDR_CAR, v, ZERO_WORD, 1'h0);
    bus(1'h0, 1'h1, ADDR_CAR, ZERO_WORD, v & CAR_MASK, 1'h0);
    for (int u = 1; u >= 0; u--) begin
      v = $urandom;
      frame_alloc = 1'h1;
      frame_addr = v;
      alloc_user = u[0];
      @(negedge mclk);
      frame_alloc = 1'h0;
      bus(1'h0, 1'h1, ADDR_CAR, ZERO_WORD, v & CAR_MASK, 1'h0);
      bus(1'h0, 1'h1, ADDR_CCR, ZERO_WORD,
        CCR_RESET | {30'h0000_0000, u[0], 1'h1}, 1'h0);
      lazy_save_done = 1'h1;
      @(negedge mclk);
      lazy_save_done = 1'h0;
      bus(1'h0, 1'h1, ADDR_CCR, ZERO_WORD,
        CCR_RESET | {30'h0000_0000, u[0], 1'h0}, 1'h0);
    end
    v = $urandom;
    cmp_valid = 1'h1;
    cmp_flags = v[3:0];
    @(negedge mclk);
    cmp_valid = 1'h0;
    es = {v[3:0], 28'h000_0000};
    check(scr_rdata, es);
    for (int i = 0; i < 6; i++) begin
      exc_flags = 6'h01 << i;
      @(negedge mclk);
      exc_flags = 6'h00;
      es[i == 5 ? 7 : i] = 1'h1;
      check(scr_rdata, es);
      @(negedge mclk);
    end
    // Clear and a fresh invalid event in one cycle: the event must win.
    scr_write = 1'h1;
    exc_flags = 6'h01;
    @(negedge mclk);
    exc_flags = 6'h00;
    check(scr_rdata, 32'h0000_0001);
    @(negedge mclk);
    scr_write = 1'h0;
    es = 32'h0000_0000;
    check(scr_rdata, es);
    for (int r = 0; r < 4; r++) begin
      v = ($urandom & 32'h0700_0000) | (r << 22);
      bus(1'h1, 1'h1, ADDR_DSCR, v | ~DSCR_MASK, ZERO_WORD, 1'h0);
      bus(1'h0, 1'h1, ADDR_DSCR, ZERO_WORD, v, 1'h0);
      new_context = 1'h1;
      @(negedge mclk);
      new_context = 1'h0;
      es = (es & ~DSCR_MASK) | v;
      check(scr_rdata, es);
      modes();
      scr_write = 1'h1;
      scr_wdata = $urandom;
      es = scr_wdata & SCR_MASK;
      @(negedge mclk);
      scr_write = 1'h0;
      check(scr_rdata, es);
      modes();
    end
    @(negedge mclk);
    conclude();
  end
endmodule : tb_fcsr_top
